// ==== core/bcr_pkg.sv ====
// constants, types and helpers of the bridge configuration register bank
// ---------------------------------------------------------------
// Operation
// - uart bit rate is 7.3728 MHz divided by 16 plus the baud divisor
// - host writes low then high byte; divisor applies on the high byte
// - two mode bits per pin; low mode register pins 3-0, high pins 7-4
// - mode upper 0 input-only, 10 push-pull, 11 open-drain
// - input-only pin never drives, its level is still filtered and read
// - push-pull pin drives its latch value continuously
// - open-drain pin pulls low on latch 0, released on latch 1, no pull-up
// - reading the pin level register returns all eight sampled pin levels
// - writing pin levels loads all latches; only output pins show them
// - own bus address, msb first after start; lsb unused and written 0
// - bus clock divisor is the high byte over the low byte
// - scl is 15 MHz over eight times the divisor; host keeps it 5 or more
// - with time-out enabled, scl held low too long resets the bus engine
// - stall counter reloads from the limit on each bus state transition
// - stall limit bit 0 enables the check, bits 7-1 hold the count
// - time-out is (divisor+1)/15 MHz times 512 times (count+1)
// - result reads F in upper nibble; 0 ok, 1 addr nack, 2 data nack, 8 time-out
// - register access happens as soon as the register address arrives
// ---------------------------------------------------------------
package bcr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_BAUD_LOW   = 8'h00;
  localparam logic [7:0] ADDR_BAUD_HIGH  = 8'h01;
  localparam logic [7:0] ADDR_MODE_LOW   = 8'h02;
  localparam logic [7:0] ADDR_MODE_HIGH  = 8'h03;
  localparam logic [7:0] ADDR_PIN_LEVEL  = 8'h04;
  localparam logic [7:0] ADDR_OWN_ADDR   = 8'h06;
  localparam logic [7:0] ADDR_BUS_DIV_LO = 8'h07;
  localparam logic [7:0] ADDR_BUS_DIV_HI = 8'h08;
  localparam logic [7:0] ADDR_STALL      = 8'h09;
  localparam logic [7:0] ADDR_RESULT     = 8'h0A;
  // reset values
  localparam logic [7:0] RST_BAUD_LOW   = 8'hF0;
  localparam logic [7:0] RST_BAUD_HIGH  = 8'h02;
  localparam logic [7:0] RST_MODE       = 8'h55;
  localparam logic [7:0] RST_PIN_LATCH  = 8'hFF;
  localparam logic [7:0] RST_OWN_ADDR   = 8'h26;
  localparam logic [7:0] RST_BUS_DIV_LO = 8'h13;
  localparam logic [7:0] RST_BUS_DIV_HI = 8'h00;
  localparam logic [7:0] RST_STALL      = 8'h66;
  // field positions and result codes
  localparam int         STALL_EN_BIT  = 0;
  localparam int         STALL_SHIFT   = 9;
  localparam logic [3:0] RESULT_FIXED  = 4'hF;
  localparam logic [3:0] RES_OK        = 4'h0;
  localparam logic [3:0] RES_ADDR_NACK = 4'h1;
  localparam logic [3:0] RES_DATA_NACK = 4'h2;
  localparam logic [3:0] RES_TIMEOUT   = 4'h8;
  localparam logic [1:0] MODE_PUSH     = 2'h2;
  localparam logic [1:0] MODE_DRAIN    = 2'h3;
  // timing
  localparam int unsigned MCLK_PERIOD_NS = 5;
  localparam int unsigned MCLK_HZ        = 1000000000 / MCLK_PERIOD_NS;
  localparam int unsigned REF_HZ         = 7372800;
  localparam int unsigned BUS_REF_HZ     = 15000000;
  localparam logic [27:0] ACC_MOD        = 28'(MCLK_HZ);
  localparam logic [27:0] REF_INC        = 28'(REF_HZ);
  localparam logic [27:0] BUS_INC        = 28'(BUS_REF_HZ);
  localparam logic [16:0] BAUD_BASE      = 17'h00010;

  typedef enum logic [1:0] {
    FRAME_OK,
    FRAME_ADDR_NACK,
    FRAME_DATA_NACK
  } bcr_frame_t;

  // {output enable, output level} for one pin
  function automatic logic [1:0] pinDrive(input logic [1:0] mode, input logic latch);
    case (mode)
      MODE_PUSH:  pinDrive = {1'b1, latch};
      MODE_DRAIN: pinDrive = {~latch, 1'b0};
      default:    pinDrive = 2'h0;
    endcase
  endfunction

  // stall units: 512 per step of the seven-bit count plus one
  function automatic logic [16:0] stallLoad(input logic [7:0] limit);
    stallLoad = 17'({10'h000, limit[7:1]} + 17'h00001) << STALL_SHIFT;
  endfunction
endpackage

// ==== core/bcr_pin_if.sv ====
// signals between the register bank and the pin controller
`timescale 1ns/1ps
interface bcr_pin_if;
  logic [15:0] pinMode;
  logic [7:0]  pinLatch;
  logic [7:0]  pinLevel;
  logic [7:0]  padIn;
  logic [7:0]  padOut;
  logic [7:0]  padOe;
  modport regs (output pinMode, pinLatch, padIn, input pinLevel, padOut, padOe);
  modport pins (input pinMode, pinLatch, padIn, output pinLevel, padOut, padOe);
endinterface

// ==== core/bcr_pin_ctrl.sv ====
// pin drivers and filtered pin input sampling
`timescale 1ns/1ps
module bcr_pin_ctrl import bcr_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register side
  bcr_pin_if.pins  pins
);
  typedef struct packed {
    logic [7:0] sync0;
    logic [7:0] sync1;
    logic [7:0] hist;
    logic [7:0] level;
    logic [7:0] out;
    logic [7:0] oe;
  } bcr_pin_t;

  bcr_pin_t pin_ff;
  bcr_pin_t nxt_pin;
  logic [1:0] drv;

  always_comb begin
    nxt_pin = pin_ff;
    drv = 2'h0;
    nxt_pin.sync0 = pins.padIn;
    nxt_pin.sync1 = pin_ff.sync0;
    nxt_pin.hist = pin_ff.sync1;
    for (int i = 0; i < 8; i++) begin
      // glitch filter: level follows only two equal samples
      if (pin_ff.sync1[i] == pin_ff.hist[i]) begin
        nxt_pin.level[i] = pin_ff.sync1[i];
      end
      drv = pinDrive(pins.pinMode[2*i +: 2], pins.pinLatch[i]);
      nxt_pin.oe[i] = drv[1];
      nxt_pin.out[i] = drv[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pins.pinLevel = pin_ff.level;
  assign pins.padOut = pin_ff.out;
  assign pins.padOe = pin_ff.oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [7:0] upperBits;
  logic [7:0] pushMask;
  logic [7:0] drainMask;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      upperBits[i] = pins.pinMode[2*i+1];
      pushMask[i] = pins.pinMode[2*i +: 2] == MODE_PUSH;
      drainMask[i] = pins.pinMode[2*i +: 2] == MODE_DRAIN;
    end
  end

  pin_input_hiz_a: assert property (@(posedge mclk) disable iff (rst)
    (pins.padOe & ~$past(upperBits)) == 8'h00)
    else $error("input-only pin is driven");
  pin_push_pull_a: assert property (@(posedge mclk) disable iff (rst)
    ((pins.padOe & $past(pushMask)) == $past(pushMask)) &&
    (((pins.padOut ^ $past(pins.pinLatch)) & $past(pushMask)) == 8'h00))
    else $error("push-pull pin not following latch");
  pin_open_drain_a: assert property (@(posedge mclk) disable iff (rst)
    ((pins.padOut & $past(drainMask)) == 8'h00) &&
    ((pins.padOe & $past(drainMask)) == (~$past(pins.pinLatch) & $past(drainMask))))
    else $error("open-drain pin drives wrongly");
endmodule

// ==== core/bcr_config_regs.sv ====
// configuration and status register bank of the uart to two-wire bridge
`timescale 1ns/1ps
module bcr_config_regs import bcr_pkg::*; (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register command port
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  // uart rate
  output logic      [15:0] baudDivisor,
  output logic             baudTick,
  // bus engine
  output logic      [15:0] busClockDivisor,
  output logic             busPhaseTick,
  output logic      [6:0]  ownBusAddress,
  input  wire logic        busActive,
  input  wire logic        busStateStep,
  input  wire logic        frameDone,
  input  wire bcr_frame_t  frameCode,
  input  wire logic        sclIn,
  output logic             busStallReset,
  // pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe
);
  typedef struct packed {
    logic [7:0]  baudLow;
    logic [7:0]  baudHigh;
    logic [15:0] baudActive;
    logic [7:0]  modeLow;
    logic [7:0]  modeHigh;
    logic [7:0]  latch;
    logic [7:0]  ownAddr;
    logic [7:0]  busDivLow;
    logic [7:0]  busDivHigh;
    logic [7:0]  stallLimit;
    logic [3:0]  result;
    logic [7:0]  rdData;
    logic        rdValid;
    logic [1:0]  sclSync;
    logic [27:0] refAcc;
    logic [27:0] busAcc;
    logic [16:0] baudCnt;
    logic        baudTick;
    logic [15:0] phaseCnt;
    logic        phaseTick;
    logic [15:0] unitCnt;
    logic [16:0] stallCnt;
    logic        stallReset;
  } bcr_regs_t;

  localparam bcr_regs_t RST_ST = '{
    baudLow:    RST_BAUD_LOW,
    baudHigh:   RST_BAUD_HIGH,
    baudActive: {RST_BAUD_HIGH, RST_BAUD_LOW},
    modeLow:    RST_MODE,
    modeHigh:   RST_MODE,
    latch:      RST_PIN_LATCH,
    ownAddr:    RST_OWN_ADDR,
    busDivLow:  RST_BUS_DIV_LO,
    busDivHigh: RST_BUS_DIV_HI,
    stallLimit: RST_STALL,
    result:     RES_OK,
    // scl idles high; a low reset value would look like a held-low line
    sclSync:    2'h3,
    stallCnt:   stallLoad(RST_STALL),
    default:    '0
  };

  bcr_regs_t  st_ff;
  bcr_regs_t  nxt_st;
  logic       refTick;
  logic       busTick;
  logic       stallRun;
  logic [15:0] busDiv;
  logic [16:0] baudLast;
  bcr_pin_if  pinIf ();

  // fractional rate: one tick per mclk-rate wrap of the accumulator
  function automatic logic [28:0] accStep(input logic [27:0] acc, input logic [27:0] inc);
    logic [28:0] sum;
    sum = {1'b0, acc} + {1'b0, inc};
    if (sum >= {1'b0, ACC_MOD}) begin
      accStep = {1'b1, 28'(sum - {1'b0, ACC_MOD})};
    end else begin
      accStep = {1'b0, sum[27:0]};
    end
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    {refTick, nxt_st.refAcc} = accStep(st_ff.refAcc, REF_INC);
    {busTick, nxt_st.busAcc} = accStep(st_ff.busAcc, BUS_INC);
    busDiv = {st_ff.busDivHigh, st_ff.busDivLow};
    baudLast = 17'(BAUD_BASE + {1'b0, st_ff.baudActive} - 17'h00001);
    nxt_st.sclSync = {st_ff.sclSync[0], sclIn};

    // uart bit clock from the reference rate
    nxt_st.baudTick = 1'b0;
    if (refTick) begin
      if (st_ff.baudCnt >= baudLast) begin
        nxt_st.baudCnt = 17'h00000;
        nxt_st.baudTick = 1'b1;
      end else begin
        nxt_st.baudCnt = 17'(st_ff.baudCnt + 17'h00001);
      end
    end

    // eight phase ticks per scl period
    nxt_st.phaseTick = 1'b0;
    if (busTick) begin
      if (17'(st_ff.phaseCnt) + 17'h00001 >= {1'b0, busDiv}) begin
        nxt_st.phaseCnt = 16'h0000;
        nxt_st.phaseTick = 1'b1;
      end else begin
        nxt_st.phaseCnt = 16'(st_ff.phaseCnt + 16'h0001);
      end
    end

    // scl stall watchdog, counted in units of divisor+1 bus ticks
    nxt_st.stallReset = 1'b0;
    stallRun = busActive && st_ff.stallLimit[STALL_EN_BIT] && !st_ff.sclSync[1];
    if (!stallRun || busStateStep) begin
      nxt_st.unitCnt = 16'h0000;
      nxt_st.stallCnt = stallLoad(st_ff.stallLimit);
    end else if (busTick) begin
      if (st_ff.unitCnt >= busDiv) begin
        nxt_st.unitCnt = 16'h0000;
        if (st_ff.stallCnt <= 17'h00001) begin
          nxt_st.stallReset = 1'b1;
          nxt_st.stallCnt = stallLoad(st_ff.stallLimit);
        end else begin
          nxt_st.stallCnt = 17'(st_ff.stallCnt - 17'h00001);
        end
      end else begin
        nxt_st.unitCnt = 16'(st_ff.unitCnt + 16'h0001);
      end
    end

    // frame result; a time-out outranks a frame end in the same cycle
    if (frameDone) begin
      case (frameCode)
        FRAME_OK:        nxt_st.result = RES_OK;
        FRAME_ADDR_NACK: nxt_st.result = RES_ADDR_NACK;
        FRAME_DATA_NACK: nxt_st.result = RES_DATA_NACK;
        default:         nxt_st.result = RES_OK;
      endcase
    end
    if (nxt_st.stallReset) begin
      nxt_st.result = RES_TIMEOUT;
    end

    // register writes, taken in the cycle the address arrives
    if (regWrEn) begin
      case (regAddr)
        ADDR_BAUD_LOW: begin
          nxt_st.baudLow = regWrData;
        end
        ADDR_BAUD_HIGH: begin
          nxt_st.baudHigh = regWrData;
          nxt_st.baudActive = {regWrData, st_ff.baudLow};
        end
        ADDR_MODE_LOW:   nxt_st.modeLow = regWrData;
        ADDR_MODE_HIGH:  nxt_st.modeHigh = regWrData;
        ADDR_PIN_LEVEL:  nxt_st.latch = regWrData;
        ADDR_OWN_ADDR:   nxt_st.ownAddr = regWrData;
        ADDR_BUS_DIV_LO: nxt_st.busDivLow = regWrData;
        ADDR_BUS_DIV_HI: nxt_st.busDivHigh = regWrData;
        ADDR_STALL:      nxt_st.stallLimit = regWrData;
        default: begin
          // result and reserved offsets drop writes
        end
      endcase
    end

    // register reads, answered on the next edge
    nxt_st.rdValid = regRdEn;
    if (regRdEn) begin
      case (regAddr)
        ADDR_BAUD_LOW:   nxt_st.rdData = st_ff.baudLow;
        ADDR_BAUD_HIGH:  nxt_st.rdData = st_ff.baudHigh;
        ADDR_MODE_LOW:   nxt_st.rdData = st_ff.modeLow;
        ADDR_MODE_HIGH:  nxt_st.rdData = st_ff.modeHigh;
        ADDR_PIN_LEVEL:  nxt_st.rdData = pinIf.pinLevel;
        ADDR_OWN_ADDR:   nxt_st.rdData = st_ff.ownAddr;
        ADDR_BUS_DIV_LO: nxt_st.rdData = st_ff.busDivLow;
        ADDR_BUS_DIV_HI: nxt_st.rdData = st_ff.busDivHigh;
        ADDR_STALL:      nxt_st.rdData = st_ff.stallLimit;
        ADDR_RESULT:     nxt_st.rdData = {RESULT_FIXED, st_ff.result};
        default:         nxt_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign pinIf.pinMode = {st_ff.modeHigh, st_ff.modeLow};
  assign pinIf.pinLatch = st_ff.latch;
  assign pinIf.padIn = pinIn;

  bcr_pin_ctrl pinCtrl (
    .mclk (mclk),
    .rst  (rst),
    .pins (pinIf.pins)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdData = st_ff.rdData;
  assign regRdValid = st_ff.rdValid;
  assign baudDivisor = st_ff.baudActive;
  assign baudTick = st_ff.baudTick;
  assign busClockDivisor = {st_ff.busDivHigh, st_ff.busDivLow};
  assign busPhaseTick = st_ff.phaseTick;
  // lsb of the own address is not used on the bus
  assign ownBusAddress = st_ff.ownAddr[7:1];
  assign busStallReset = st_ff.stallReset;
  assign pinOut = pinIf.padOut;
  assign pinOe = pinIf.padOe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence lowWrite;
    regWrEn && regAddr == ADDR_BAUD_LOW;
  endsequence
  sequence highWrite;
    regWrEn && regAddr == ADDR_BAUD_HIGH;
  endsequence

  baud_pair_apply_a: assert property (@(posedge mclk) disable iff (rst)
    lowWrite ##1 highWrite |=>
      baudDivisor == {$past(regWrData), $past(regWrData, 2)})
    else $error("baud divisor not applied from low and high");
  baud_low_hold_a: assert property (@(posedge mclk) disable iff (rst)
    lowWrite |=> $stable(baudDivisor))
    else $error("baud divisor changed on low byte");
  baud_tick_a: assert property (@(posedge mclk) disable iff (rst)
    baudTick |-> st_ff.baudCnt == 17'h00000 ##1 !baudTick)
    else $error("baud tick without counter wrap");
  read_answer_a: assert property (@(posedge mclk) disable iff (rst)
    regRdEn |=> regRdValid)
    else $error("read not answered next cycle");
  result_read_a: assert property (@(posedge mclk) disable iff (rst)
    regRdEn && regAddr == ADDR_RESULT |=> regRdData[7:4] == RESULT_FIXED)
    else $error("result upper nibble wrong");
  result_source_a: assert property (@(posedge mclk) disable iff (rst)
    !$stable(st_ff.result) |-> $past(frameDone) || busStallReset)
    else $error("result changed without frame end");
  stall_code_a: assert property (@(posedge mclk) disable iff (rst)
    busStallReset |-> st_ff.result == RES_TIMEOUT)
    else $error("time-out not reported");
  stall_reload_a: assert property (@(posedge mclk) disable iff (rst)
    busActive && busStateStep |=> st_ff.stallCnt == stallLoad($past(st_ff.stallLimit)))
    else $error("stall counter not reloaded");
  bus_div_write_a: assert property (@(posedge mclk) disable iff (rst)
    regWrEn && regAddr == ADDR_BUS_DIV_HI |=> busClockDivisor[15:8] == $past(regWrData))
    else $error("bus divisor high byte not stored");
  pin_read_a: assert property (@(posedge mclk) disable iff (rst)
    regRdEn && regAddr == ADDR_PIN_LEVEL |=> regRdData == $past(pinIf.pinLevel))
    else $error("pin level read wrong");
endmodule

// ==== tb/bcr_host_model.sv ====
// host model issuing register write and read commands to the bank
`timescale 1ns/1ps
module bcr_host_model (
  // clock
  input  wire logic       mclk,
  // register command port
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regRdValid
);
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // ---------------------------------------------
  // bus cycles
  // ---------------------------------------------
  // idle address and data show the inverse of the last value, never a stale copy
  task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    regWrEn   <= 1'b1;
    regAddr   <= addr;
    regWrData <= data;
    @(posedge mclk);
    regWrEn   <= 1'b0;
    regAddr   <= ~addr;
    regWrData <= ~data;
  endtask

  task automatic rdReg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge mclk);
    regRdEn <= 1'b1;
    regAddr <= addr;
    @(posedge mclk);
    regRdEn <= 1'b0;
    regAddr <= ~addr;
    #1;
    ok   = regRdValid;
    data = regRdData;
  endtask

  // ---------------------------------------------
  // host-side programming habits
  // ---------------------------------------------
  // low and high back to back, the way a host streams the pair in one command
  task automatic setBaud(input logic [15:0] div);
    @(posedge mclk);
    regWrEn   <= 1'b1;
    regAddr   <= 8'h00;
    regWrData <= div[7:0];
    @(posedge mclk);
    regAddr   <= 8'h01;
    regWrData <= div[15:8];
    @(posedge mclk);
    regWrEn   <= 1'b0;
    regAddr   <= 8'hFE;
    regWrData <= ~div[15:8];
  endtask

  // a divisor below the minimum of 5 is never requested
  task automatic setBusDiv(input logic [15:0] div);
    logic [15:0] d;
    d = (div < 16'h0005) ? 16'h0005 : div;
    wrReg(8'h07, d[7:0]);
    wrReg(8'h08, d[15:8]);
  endtask

  task automatic setOwnAddr(input logic [7:0] adr);
    wrReg(8'h06, {adr[7:1], 1'b0});
  endtask
endmodule

// ==== tb/bcr_config_regs_tb_top.sv ====
// self-checking bench of the bridge configuration register bank
`timescale 1ns/1ps
module bcr_config_regs_tb_top;
  import bcr_pkg::*;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic        mclk;
  logic        rst;
  logic        regWrEn;
  logic        regRdEn;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic        regRdValid;
  logic [15:0] baudDivisor;
  logic        baudTick;
  logic [15:0] busClockDivisor;
  logic        busPhaseTick;
  logic [6:0]  ownBusAddress;
  logic        busActive;
  logic        busStateStep;
  logic        frameDone;
  bcr_frame_t  frameCode;
  logic        sclIn;
  logic        busStallReset;
  wire  [7:0]  pinIn;
  logic [7:0]  pinOut;
  logic [7:0]  pinOe;
  logic [7:0]  extLevel;
  logic [7:0]  rdVal;
  logic        rdOk;
  int          errCount;
  int          nTests;

  // pad level: driver wins, else the external source; no pull-up inside
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

  bcr_config_regs uut (
    .mclk(mclk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .baudDivisor(baudDivisor), .baudTick(baudTick), .busClockDivisor(busClockDivisor),
    .busPhaseTick(busPhaseTick), .ownBusAddress(ownBusAddress), .busActive(busActive),
    .busStateStep(busStateStep), .frameDone(frameDone), .frameCode(frameCode),
    .sclIn(sclIn), .busStallReset(busStallReset), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe)
  );

  bcr_host_model host (
    .mclk(mclk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ---------------------------------------------
  // compare and report
  // ---------------------------------------------
  task automatic check8(input logic [7:0] exp, input logic [7:0] act);
    nTests++;
    if (act !== exp) begin
      errCount++;
      $display("wrong value at %0t ns: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic check16(input logic [15:0] exp, input logic [15:0] act);
    nTests++;
    if (act !== exp) begin
      errCount++;
      $display("wrong value at %0t ns: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic checkSpan(input int lo, input int hi, input int act);
    nTests++;
    if (act < lo || act > hi) begin
      errCount++;
      $display("wrong value at %0t ns: expected %h..%h got %h", $time, lo, hi, act);
    end
  endtask

  task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
    host.rdReg(addr, rdVal, rdOk);
    check8(8'h01, {7'h00, rdOk});
    check8(exp, rdVal);
  endtask

  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ticks seen on a rate output over a fixed span
  task automatic countTicks(input bit bus, input int span, output int cnt);
    cnt = 0;
    repeat (span) begin
      @(negedge mclk);
      cnt += bus ? int'(busPhaseTick) : int'(baudTick);
    end
  endtask

  // {oe, out} per pin worked out from mode pairs and latches
  function automatic logic [15:0] expPins(input logic [15:0] mode, input logic [7:0] latch);
    logic [7:0] oe;
    logic [7:0] out;
    for (int i = 0; i < 8; i++) begin
      oe[i]  = mode[2*i+1] & (~mode[2*i] | ~latch[i]);
      out[i] = mode[2*i+1] & ~mode[2*i] & latch[i];
    end
    return {oe, out};
  endfunction

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic testReset();
    logic [7:0] adr [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
                             8'h09, 8'h0C};
    logic [7:0] val [10] = '{8'hF0, 8'h02, 8'h55, 8'h55, 8'h00, 8'h26, 8'h13, 8'h00,
                             8'h66, 8'h00};
    host.wrReg(8'h05, 8'h77);
    host.wrReg(8'h0C, 8'h77);
    for (int i = 0; i < 10; i++)
      readCheck(adr[i], val[i]);
    check16(16'h02F0, baudDivisor);
    check16(16'h0013, busClockDivisor);
    check8(8'h13, {1'b0, ownBusAddress});
    check8(8'h00, pinOe);
    readCheck(8'h04, extLevel);
    $display("test reset done, mismatches %0d", errCount);
  endtask

  task automatic testRates();
    int cnt;
    host.wrReg(8'h00, 8'h34);
    repeat (3) @(posedge mclk);
    check16(16'h02F0, baudDivisor);
    host.wrReg(8'h01, 8'h12);
    repeat (2) @(posedge mclk);
    check16(16'h1234, baudDivisor);
    host.setBaud(16'h0000);
    countTicks(1'b0, 4340, cnt);
    checkSpan(9, 11, cnt);
    host.setBaud(16'h0010);
    countTicks(1'b0, 4340, cnt);
    checkSpan(4, 6, cnt);
    check16(16'h0010, baudDivisor);
    host.setBusDiv(16'h0005);
    readCheck(8'h07, 8'h05);
    check16(16'h0005, busClockDivisor);
    countTicks(1'b1, 4000, cnt);
    checkSpan(59, 61, cnt);
    host.setOwnAddr(8'hA4);
    readCheck(8'h06, 8'hA4);
    check8(8'h52, {1'b0, ownBusAddress});
    $display("test rates done, mismatches %0d", errCount);
  endtask

  task automatic testPins();
    logic [7:0]  lat [3] = '{8'h00, 8'hFF, 8'hA5};
    logic [15:0] e;
    @(posedge mclk);
    extLevel <= 8'h5A;
    host.wrReg(8'h02, 8'hE4);
    host.wrReg(8'h03, 8'hE4);
    for (int i = 0; i < 3; i++) begin
      host.wrReg(8'h04, lat[i]);
      repeat (6) @(posedge mclk);
      e = expPins(16'hE4E4, lat[i]);
      check8(e[15:8], pinOe);
      check8(e[7:0], pinOut);
      readCheck(8'h04, (e[15:8] & e[7:0]) | (~e[15:8] & 8'h5A));
    end
    $display("test pins done, mismatches %0d", errCount);
  endtask

  task automatic testResult();
    logic [7:0] exp [3] = '{8'hF0, 8'hF1, 8'hF2};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      frameDone <= 1'b1;
      frameCode <= bcr_frame_t'(i);
      @(posedge mclk);
      frameDone <= 1'b0;
      readCheck(8'h0A, exp[i]);
    end
    host.wrReg(8'h0A, 8'h00);
    readCheck(8'h0A, 8'hF2);
    $display("test result done, mismatches %0d", errCount);
  endtask

  // one reload in mid-wait restarts the wait, so the time-out comes a whole period after the reload
  task automatic testStall();
    int n;
    host.wrReg(8'h09, 8'h01);
    readCheck(8'h09, 8'h01);
    @(posedge mclk);
    busActive <= 1'b1;
    sclIn     <= 1'b0;
    n = 0;
    // outputs looked at on the falling edge, clear of the launching edge
    while (busStallReset !== 1'b1 && n < 70000) begin
      @(posedge mclk);
      n++;
      busStateStep <= (n == 20000);
      @(negedge mclk);
    end
    checkSpan(20000 + 40960 - 400, 20000 + 40960 + 400, n);
    @(negedge mclk);
    check8(8'h00, {7'h00, busStallReset});
    readCheck(8'h0A, 8'hF8);
    @(posedge mclk);
    sclIn     <= 1'b1;
    busActive <= 1'b0;
    $display("test stall done, mismatches %0d", errCount);
  endtask

  // ---------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------
  initial begin
    errCount     = 0;
    nTests       = 0;
    rst          = 1'b1;
    busActive    = 1'b0;
    busStateStep = 1'b0;
    frameDone    = 1'b0;
    frameCode    = FRAME_OK;
    sclIn        = 1'b1;
    extLevel     = 8'hC3;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    testReset();
    testRates();
    testPins();
    testResult();
    testStall();
    reportAndStop();
  end

  // whole run needs about 75k cycles
  initial begin
    repeat (95000) @(posedge mclk);
    errCount++;
    $display("watchdog expired at %0t ns", $time);
    reportAndStop();
  end
endmodule
